// ==== clock_synth_control_regs.sv ====
/*
 * Control register bank of a spread-spectrum clock synthesizer, reached
 * over a two-wire serial link (byte, block write and read).
 * Assumes scl/sda are already synchronous to clk and the pad logic turns
 * sda_oe into an open-drain low drive.
 */
// Notes on behaviour
// - byte0 bit2 enables differential output, powers 1
// - byte2 bit7 picks spread depth, powers 1
// - byte2 bit2 switches spreading on, powers 0
// - byte6 bit6 enters test clock mode
// - byte6 bit7: hi-z or divided reference
// - byte7 returns fixed revision and vendor code
// - all bytes take defaults at power-up
// - command: single/block, chip select 00, offset
// - answer only slave address D2 write form and D3 read form
// - block transfers ascend from byte zero
// - block read sends byte count first
`timescale 1ns/100ps
`include "clock_synth_params.svh"

module clock_synth_control_regs #(
    parameter logic [3:0] REVISION_CODE = 4'hA, // arbitrary value
    parameter logic [3:0] VENDOR_CODE = 4'h5 // arbitrary value
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // serial link
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // controls to the synthesizer
    output clock_synth_pkg::synth_ctrl_t ctrl,
    output logic clk_out_drive,
    output logic clk_out_refdiv
);

    clock_synth_pkg::bank_state_t s_r;
    clock_synth_pkg::bank_state_t s_nxt;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic [7:0] id_byte;

    // =================================================================
    // read data selection
    assign id_byte = {REVISION_CODE, VENDOR_CODE};

    function automatic logic [7:0] rd_byte(input logic [6:0][7:0] regs,
                                           input logic [4:0] ofs,
                                           input logic [7:0] id);
        logic [7:0] v;
        v = 8'h00;
        if (ofs < `NUM_RW_BYTES) begin
            v = regs[ofs[2:0]];
        end else if (ofs == `OFS_IDENTIFICATION) begin
            v = id;
        end
        return v;
    endfunction : rd_byte

    // =================================================================
    // link condition detection
    assign scl_rise = scl_in & ~s_r.scl_q;
    assign scl_fall = ~scl_in & s_r.scl_q;
    // start and stop are sda edges while scl stays high
    assign start_seen = scl_in & s_r.scl_q & s_r.sda_q & ~sda_in;
    assign stop_seen = scl_in & s_r.scl_q & ~s_r.sda_q & sda_in;

    // =================================================================
    // next state
    always_comb begin
        s_nxt = s_r;
        s_nxt.scl_q = scl_in;
        s_nxt.sda_q = sda_in;
        if (start_seen) begin
            // repeated start keeps pointer and mode for the read phase
            s_nxt.st = clock_synth_pkg::ST_RX;
            s_nxt.phase = clock_synth_pkg::PH_ADDR;
            s_nxt.cnt = 4'h0;
            s_nxt.sda_oe = 1'b0;
        end else if (stop_seen) begin
            s_nxt.st = clock_synth_pkg::ST_IDLE;
            s_nxt.sda_oe = 1'b0;
        end else begin
            case (s_r.st)
                clock_synth_pkg::ST_IDLE: begin
                    s_nxt.sda_oe = 1'b0;
                end
                clock_synth_pkg::ST_RX: begin
                    if (scl_rise && s_r.cnt < `BITS_PER_BYTE) begin
                        s_nxt.shreg = {s_r.shreg[6:0], sda_in};
                        s_nxt.cnt = s_r.cnt + 4'h1;
                    end else if (scl_fall && s_r.cnt == `BITS_PER_BYTE) begin
                        s_nxt.cnt = 4'h0;
                        s_nxt.st = clock_synth_pkg::ST_ACK;
                        s_nxt.sda_oe = 1'b1; // every taken byte is acknowledged, except an address byte for a foreign device
                        case (s_r.phase)
                            clock_synth_pkg::PH_ADDR: begin
                                if (s_r.shreg[7:1] != `SLAVE_ADDR7) begin
                                    s_nxt.st = clock_synth_pkg::ST_IDLE;
                                    s_nxt.sda_oe = 1'b0;
                                end else if (s_r.shreg[0]) begin
                                    s_nxt.is_read = 1'b1;
                                    if (s_r.block) begin
                                        s_nxt.shreg = `BLOCK_BYTE_COUNT;
                                    end else begin
                                        s_nxt.shreg = rd_byte(s_r.regs, s_r.ptr, id_byte);
                                        s_nxt.ptr = s_r.ptr + 5'h01;
                                    end
                                end else begin
                                    s_nxt.is_read = 1'b0;
                                    s_nxt.phase = clock_synth_pkg::PH_CMD;
                                end
                            end
                            clock_synth_pkg::PH_CMD: begin
                                s_nxt.cmd_ok = (s_r.shreg[6:5] == `CMD_CHIP_SEL_OK);
                                s_nxt.block = ~s_r.shreg[`CMD_BIT_SINGLE];
                                // block access always starts at byte zero
                                s_nxt.ptr = s_r.shreg[`CMD_BIT_SINGLE] ?
                                    s_r.shreg[4:0] : 5'h00;
                                s_nxt.phase = s_r.shreg[`CMD_BIT_SINGLE] ?
                                    clock_synth_pkg::PH_DATA : clock_synth_pkg::PH_COUNT;
                            end
                            clock_synth_pkg::PH_COUNT: begin
                                // byte count of a block write carries no meaning here
                                s_nxt.phase = clock_synth_pkg::PH_DATA;
                            end
                            default: begin
                                // writes past the last control byte are dropped
                                if (s_r.cmd_ok && s_r.ptr < `NUM_RW_BYTES) begin
                                    s_nxt.regs[s_r.ptr[2:0]] = s_r.shreg;
                                end
                                if (s_r.ptr != 5'h1F) begin
                                    s_nxt.ptr = s_r.ptr + 5'h01;
                                end
                            end
                        endcase
                    end
                end
                clock_synth_pkg::ST_ACK: begin
                    if (scl_fall) begin
                        if (s_r.is_read && s_r.phase == clock_synth_pkg::PH_ADDR) begin
                            s_nxt.st = clock_synth_pkg::ST_TX;
                            s_nxt.sda_oe = ~s_r.shreg[7];
                        end else begin
                            s_nxt.st = clock_synth_pkg::ST_RX;
                            s_nxt.sda_oe = 1'b0;
                        end
                    end
                end
                clock_synth_pkg::ST_TX: begin
                    // data changes only while scl is low, msb first
                    if (scl_fall) begin
                        if (s_r.cnt == `BITS_PER_BYTE - 4'h1) begin
                            s_nxt.cnt = 4'h0;
                            s_nxt.sda_oe = 1'b0;
                            s_nxt.st = clock_synth_pkg::ST_TX_ACK;
                        end else begin
                            s_nxt.cnt = s_r.cnt + 4'h1;
                            s_nxt.shreg = {s_r.shreg[6:0], 1'b0};
                            s_nxt.sda_oe = ~s_r.shreg[6];
                        end
                    end
                end
                clock_synth_pkg::ST_TX_ACK: begin
                    if (scl_rise) begin
                        if (sda_in) begin
                            // not-acknowledge ends the read; wait for stop
                            s_nxt.st = clock_synth_pkg::ST_IDLE;
                        end else begin
                            s_nxt.shreg = rd_byte(s_r.regs, s_r.ptr, id_byte);
                            if (s_r.ptr != 5'h1F) begin
                                s_nxt.ptr = s_r.ptr + 5'h01;
                            end
                            s_nxt.st = clock_synth_pkg::ST_TX_NEXT;
                        end
                    end
                end
                clock_synth_pkg::ST_TX_NEXT: begin
                    if (scl_fall) begin
                        s_nxt.st = clock_synth_pkg::ST_TX;
                        s_nxt.sda_oe = ~s_r.shreg[7];
                    end
                end
                default: begin
                    s_nxt.st = clock_synth_pkg::ST_IDLE;
                    s_nxt.sda_oe = 1'b0;
                end
            endcase
        end
    end

    // =================================================================
    // state register; reset stands for power-up
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_r.st <= clock_synth_pkg::ST_IDLE;
            s_r.phase <= clock_synth_pkg::PH_ADDR;
            s_r.scl_q <= 1'b1;
            s_r.sda_q <= 1'b1;
            s_r.cnt <= 4'h0;
            s_r.shreg <= 8'h00;
            s_r.ptr <= 5'h00;
            s_r.block <= 1'b0;
            s_r.is_read <= 1'b0;
            s_r.cmd_ok <= 1'b0;
            s_r.sda_oe <= 1'b0;
            s_r.regs[0] <= `PUP_OUTPUT_ENABLE_CTRL;
            s_r.regs[1] <= `PUP_SPARE_CTRL_A;
            s_r.regs[2] <= `PUP_SPREAD_CTRL;
            s_r.regs[3] <= `PUP_SPARE_CTRL_B;
            s_r.regs[4] <= `PUP_SPARE_CTRL_C;
            s_r.regs[5] <= `PUP_SPARE_CTRL_D;
            s_r.regs[6] <= `PUP_TEST_CLOCK_CTRL;
        end else begin
            s_r <= s_nxt;
        end
    end

    // =================================================================
    // pins and controls: sda_oe and ctrl straight from flip-flops, output pair decoded from them, sda_out tied low
    assign sda_out = 1'b0;
    assign sda_oe = s_r.sda_oe;
    assign ctrl.diff_clock_out_enable = s_r.regs[0][`BIT_DIFF_CLOCK_OUT_ENABLE];
    assign ctrl.spread_depth_select = s_r.regs[2][`BIT_SPREAD_DEPTH_SELECT];
    assign ctrl.spread_on = s_r.regs[2][`BIT_SPREAD_ON];
    assign ctrl.test_mode = s_r.regs[6][`BIT_TEST_MODE];
    assign ctrl.test_select = s_r.regs[6][`BIT_TEST_SELECT];
    // test mode overrides the enable: hi-z or divided reference
    assign clk_out_drive = ctrl.test_mode ? ctrl.test_select :
                           ctrl.diff_clock_out_enable;
    assign clk_out_refdiv = ctrl.test_mode & ctrl.test_select;

endmodule : clock_synth_control_regs

// ==== clock_synth_params.svh ====
/*
 * Offsets, field positions, power-up values and link constants for the
 * clock synthesizer control register bank.
 * Assumes inclusion by bare name from the package and the design module.
 */
`ifndef CLOCK_SYNTH_PARAMS_SVH
`define CLOCK_SYNTH_PARAMS_SVH

// =====================================================================
// register byte offsets
`define OFS_OUTPUT_ENABLE_CTRL 5'h00
`define OFS_SPARE_CTRL_A 5'h01
`define OFS_SPREAD_CTRL 5'h02
`define OFS_SPARE_CTRL_B 5'h03
`define OFS_SPARE_CTRL_C 5'h04
`define OFS_SPARE_CTRL_D 5'h05
`define OFS_TEST_CLOCK_CTRL 5'h06
`define OFS_IDENTIFICATION 5'h07
`define NUM_RW_BYTES 5'h07

// =====================================================================
// field positions
`define BIT_DIFF_CLOCK_OUT_ENABLE 2
`define BIT_SPREAD_DEPTH_SELECT 7
`define BIT_SPREAD_ON 2
`define BIT_TEST_MODE 6
`define BIT_TEST_SELECT 7

// =====================================================================
// power-up values, reserved bits included
`define PUP_OUTPUT_ENABLE_CTRL 8'h7C
`define PUP_SPARE_CTRL_A 8'h00
`define PUP_SPREAD_CTRL 8'hEB
`define PUP_SPARE_CTRL_B 8'hAF
`define PUP_SPARE_CTRL_C 8'h01
`define PUP_SPARE_CTRL_D 8'h00
`define PUP_TEST_CLOCK_CTRL 8'h13

// =====================================================================
// serial link constants
`define SLAVE_ADDR7 7'h69
`define CMD_BIT_SINGLE 7
`define CMD_CHIP_SEL_OK 2'h0
`define BLOCK_BYTE_COUNT 8'h08
`define BITS_PER_BYTE 4'h8

`endif

// ==== clock_synth_pkg.sv ====
/*
 * Types for the clock synthesizer control register bank.
 * Assumes clock_synth_params.svh is on the include path.
 */
`include "clock_synth_params.svh"

package clock_synth_pkg;

    // =================================================================
    // link engine states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RX = 3'b001,
        ST_ACK = 3'b010,
        ST_TX = 3'b011,
        ST_TX_ACK = 3'b100,
        ST_TX_NEXT = 3'b101
    } state_t;

    // which byte of a frame is being received
    typedef enum logic [1:0] {
        PH_ADDR = 2'b00,
        PH_CMD = 2'b01,
        PH_COUNT = 2'b10,
        PH_DATA = 2'b11
    } phase_t;

    // =================================================================
    // whole module state
    typedef struct packed {
        state_t st;
        phase_t phase;
        logic scl_q;
        logic sda_q;
        logic [3:0] cnt;
        logic [7:0] shreg;
        logic [4:0] ptr;
        logic block;
        logic is_read;
        logic cmd_ok;
        logic sda_oe;
        logic [6:0][7:0] regs;
    } bank_state_t;

    // control bits handed to the analog side
    typedef struct packed {
        logic diff_clock_out_enable;
        logic spread_depth_select;
        logic spread_on;
        logic test_mode;
        logic test_select;
    } synth_ctrl_t;

endpackage : clock_synth_pkg

// ==== clock_synth_control_regs_props.sv ====
/*
 * Concurrent checks for the clock synthesizer control register bank.
 * Assumes it is bound to the design top and sees only its ports.
 */
`timescale 1ns/100ps
module synth_regs_props (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // serial link
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    // controls to the synthesizer
    input clock_synth_pkg::synth_ctrl_t ctrl,
    input wire logic clk_out_drive,
    input wire logic clk_out_refdiv
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    // =================================================================
    // bus conditions seen on the wires
    sequence start_seen;
        scl_in && $fell(sda_in);
    endsequence
    sequence stop_seen;
        scl_in && $rose(sda_in);
    endsequence
    // power-up values show on the first cycle out of reset
    reset_ctrl_a: assert property ($fell(sys_rst) |-> ctrl == 5'h18)
        else $error("control bits not at power-up values");
    reset_link_a: assert property ($fell(sys_rst) |-> !sda_oe && clk_out_drive)
        else $error("link or output pair wrong after reset");
    // output pair decode follows the registered bits at once
    drive_decode_a: assert property (clk_out_drive == (ctrl.test_mode ?
        ctrl.test_select : ctrl.diff_clock_out_enable))
        else $error("output pair drive decode wrong");
    refdiv_decode_a: assert property (clk_out_refdiv == (ctrl.test_mode && ctrl.test_select))
        else $error("divided reference select wrong");
    // writes land only at a byte boundary, while the serial clock is low
    write_timing_a: assert property ($changed(ctrl) && !$past(sys_rst) |-> !scl_in)
        else $error("control bits changed with serial clock high");
    oe_scl_low_a: assert property ($changed(sda_oe) |-> !scl_in)
        else $error("data drive changed with serial clock high");
    // no drive during the start of an address byte, none after a stop
    start_quiet_a: assert property (start_seen |=> !sda_oe [*8])
        else $error("data driven right after a start");
    stop_release_a: assert property (stop_seen |=> !sda_oe [*4])
        else $error("data still driven after a stop");
endmodule : synth_regs_props

bind clock_synth_control_regs synth_regs_props synth_regs_props_i (
    .clk(clk), .sys_rst(sys_rst), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .ctrl(ctrl),
    .clk_out_drive(clk_out_drive), .clk_out_refdiv(clk_out_refdiv));

// ==== host_i2c_model.sv ====
/*
 * Two-wire bus controller model: drives the serial clock and data wire.
 * Assumes the device pulls data low through dev_oe; the wire has a pull-up.
 */
`timescale 1ns/100ps
module host_i2c_model (
    // pacing clock
    input wire logic clk,
    // device pull-down
    input wire logic dev_oe,
    // bus wires
    output logic scl,
    output logic sda
);
    logic host_sda;
    // wired-and: a released wire reads high through the pull-up
    assign sda = host_sda & ~dev_oe;
    // idle bus, clock stands high between frames
    initial begin
        scl = 1'b1;
        host_sda = 1'b1;
    end
    // one phase is 4 clk, well above the 3 the sampler needs
    task automatic step(input logic s, input logic d);
        scl = s;
        host_sda = d;
        repeat (4) @(posedge clk);
        #1;
    endtask : step
    // data falls while the clock is high; from an idle bus the clock stays put,
    // so no stray clock pulse is sent outside a frame
    task automatic start();
        if (!scl) begin
            step(1'b0, 1'b1);
            step(1'b1, 1'b1);
        end
        step(1'b1, 1'b0);
        step(1'b0, 1'b0);
    endtask : start
    // data rises while the clock is high
    task automatic stop();
        step(1'b0, 1'b0);
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
    endtask : stop
    // data changes only while the clock is low
    task automatic xbit(input logic b, output logic r);
        step(1'b0, b);
        step(1'b1, b);
        r = sda;
        step(1'b0, b);
    endtask : xbit
    // msb first, then the acknowledge slot (ai=1 releases or refuses)
    task automatic xbyte(input logic [7:0] d, input logic ai, output logic [7:0] q,
        output logic ao);
        for (int i = 7; i >= 0; i--) begin
            xbit(d[i], q[i]);
        end
        xbit(ai, ao);
    endtask : xbyte
endmodule : host_i2c_model

// ==== clock_synth_control_regs_tb.sv ====
/*
 * Self-checking bench for the control register bank.
 * Assumes the host model and the bound checker are compiled alongside.
 */
`timescale 1ns/100ps
module clock_synth_control_regs_tb;
    typedef struct packed {
        logic [7:0] ofs;
        logic [7:0] d;
        logic [7:0] e;
        logic [7:0] c;
    } row_t;
    localparam logic [3:0] REV = 4'h3; // arbitrary value
    localparam logic [3:0] VEN = 4'hC; // arbitrary value
    localparam logic [7:0] ID = {REV, VEN};
    localparam logic [7:0] DEF [8] = '{8'h7C, 8'h00, 8'hEB, 8'hAF, 8'h01, 8'h00, 8'h13, ID};
    // offset, written, read back, {0, ctrl, drive, refdiv}
    localparam row_t ROWS [8] = '{32'h00_78_78_20, 32'h00_7C_7C_62, 32'h02_6F_6F_52,
        32'h02_EB_EB_62, 32'h06_53_53_68, 32'h06_D3_D3_6F, 32'h06_13_13_62,
        {8'h07, 8'h00, ID, 8'h62}};
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic scl;
    logic sda;
    logic sda_out;
    logic sda_oe;
    clock_synth_pkg::synth_ctrl_t ctrl;
    logic drv;
    logic refd;
    logic [7:0] q;
    logic a;
    int err_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    // =================================================================
    // design and far side
    clock_synth_control_regs #(.REVISION_CODE(REV), .VENDOR_CODE(VEN))
        clock_synth_control_regs_i (.clk(clk), .sys_rst(sys_rst), .scl_in(scl),
        .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .ctrl(ctrl),
        .clk_out_drive(drv), .clk_out_refdiv(refd));
    host_i2c_model host_i2c_model_i (.clk(clk), .dev_oe(sda_oe), .scl(scl), .sda(sda));
    // 25 MHz
    initial begin
        forever #20 clk = ~clk;
    end
    // hang guard, about three and a half times the expected run
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            err_count++;
            $display("mismatch at %0t: run did not finish", $time);
            tally_and_finish();
        end
    end
    // =================================================================
    // shared tasks
    task chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task wb(input logic [7:0] d);
        host_i2c_model_i.xbyte(d, 1'b1, q, a);
        chk({7'h00, a}, 8'h00);
    endtask : wb
    task head(input logic [7:0] cmd);
        host_i2c_model_i.start();
        wb(8'hD2);
        wb(cmd);
    endtask : head
    task wr(input logic [7:0] cmd, input logic [7:0] d);
        head(cmd);
        wb(d);
        host_i2c_model_i.stop();
    endtask : wr
    task rd(input logic [7:0] cmd, input logic [7:0] e);
        head(cmd);
        host_i2c_model_i.start();
        wb(8'hD3);
        host_i2c_model_i.xbyte(8'hFF, 1'b1, q, a);
        chk(q, e);
        host_i2c_model_i.stop();
    endtask : rd
    task tally_and_finish();
        if (err_count == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : tally_and_finish
    // =================================================================
    // main sequence
    initial begin
        repeat (10) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        @(posedge clk);
        #1;
        chk({1'b0, ctrl, drv, refd}, 8'h62);
        // open-drain data: the driven level is always low
        chk({7'h00, sda_out}, 8'h00);
        // block read right after power-up: count first, then bytes ascending
        head(8'h00);
        host_i2c_model_i.start();
        wb(8'hD3);
        host_i2c_model_i.xbyte(8'hFF, 1'b0, q, a);
        chk(q, 8'h08);
        for (int j = 0; j < 8; j++) begin
            host_i2c_model_i.xbyte(8'hFF, j == 7, q, a);
            chk(q, DEF[j]);
        end
        host_i2c_model_i.stop();
        // reserved bits always written back at their power-up values
        for (int i = 0; i < 8; i++) begin
            wr({3'h4, ROWS[i].ofs[4:0]}, ROWS[i].d);
            rd({3'h4, ROWS[i].ofs[4:0]}, ROWS[i].e);
            chk({1'b0, ctrl, drv, refd}, ROWS[i].c);
        end
        // block write of two bytes from offset zero
        head(8'h00);
        wb(8'h02);
        wb(8'h78);
        wb(8'h00);
        host_i2c_model_i.stop();
        chk({1'b0, ctrl, drv, refd}, 8'h20);
        rd(8'h80, 8'h78);
        wr(8'h80, 8'h7C);
        // foreign address is left unanswered
        host_i2c_model_i.start();
        host_i2c_model_i.xbyte(8'hD4, 1'b1, q, a);
        chk({7'h00, a}, 8'h01);
        host_i2c_model_i.stop();
        // nonzero select field drops the write; far offsets read zero
        wr(8'hA2, 8'h6F);
        rd(8'h82, 8'hEB);
        rd(8'h89, 8'h00);
        // second reset in mid-run restores power-up values
        wr(8'h82, 8'h6F);
        sys_rst = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        @(posedge clk);
        #1;
        rd(8'h82, 8'hEB);
        tally_and_finish();
    end
endmodule : clock_synth_control_regs_tb
